// file: design/adcps_defs.svh
// constants for the conversion-select power mode sequencer
`ifndef ADCPS_DEFS_SVH
`define ADCPS_DEFS_SVH

// clock rate and documented times
`define ADCPS_CLK_MHZ 40
`define ADCPS_PARTIAL_WAKE_NS 200
`define ADCPS_FULL_WAKE_MS 6
// least wake times, rounded up to whole cycles
`define ADCPS_PARTIAL_WAKE_CYC ((`ADCPS_PARTIAL_WAKE_NS * `ADCPS_CLK_MHZ + 999) / 1000)
`define ADCPS_FULL_WAKE_CYC (`ADCPS_FULL_WAKE_MS * `ADCPS_CLK_MHZ * 1000)

// serial-clock falling edge counts since chip select fell
`define ADCPS_CNT_GLITCH 6'h02
`define ADCPS_CNT_NORMAL 6'h0A
`define ADCPS_CNT_RESULT 6'h10
`define ADCPS_CNT_TRAIL 6'h11
`define ADCPS_CNT_DUAL 6'h20

// widths
`define ADCPS_RES_W 14
`define ADCPS_FRAME_W 32
`define ADCPS_WAKE_W 18

// pin reset value and two-bit frame zero fill
`define ADCPS_PINS_IDLE 2'h2
`define ADCPS_ZERO2 2'h0

`endif

// file: design/adcps_pkg.sv
// types shared by the power mode sequencer files
package adcps_pkg;
    // power modes, one-hot
    typedef enum logic [2:0] {
        ADCPS_NORMAL = 3'h1,
        ADCPS_PARTIAL = 3'h2,
        ADCPS_FULL = 3'h4
    } adcps_mode_t;

    // serial port pins from the host
    typedef struct packed {
        logic cs_n;
        logic sclk;
    } adcps_pins_t;

    // one result from each converter
    typedef struct packed {
        logic [13:0] res_a;
        logic [13:0] res_b;
    } adcps_result_t;
endpackage

// file: design/adcps_pin_sync.sv
// two-flop synchroniser for the serial port pins
`timescale 1ns/1ps
`include "adcps_defs.svh"
module adcps_pin_sync
    import adcps_pkg::*;
(
    input wire logic ref_clk_in,
    input wire logic rst_in,
    input wire adcps_pins_t pins_in,
    output adcps_pins_t pins_out
);
    adcps_pins_t meta_reg;
    adcps_pins_t sync_reg;

    // first stage feeds only the second; idle is chip select high
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            meta_reg <= `ADCPS_PINS_IDLE;
            sync_reg <= `ADCPS_PINS_IDLE;
        end else begin
            meta_reg <= pins_in;
            sync_reg <= meta_reg;
        end
    end

    assign pins_out = sync_reg;
endmodule // adcps_pin_sync

// file: design/adcps_wake_timer.sv
// power-up countdown, ready flag held in a register
`timescale 1ns/1ps
`include "adcps_defs.svh"
module adcps_wake_timer (
    input wire logic ref_clk_in,
    input wire logic rst_in,
    input wire logic start_in,
    input wire logic abort_in,
    input wire logic [`ADCPS_WAKE_W-1:0] load_in,
    output logic ready_out
);
    logic [`ADCPS_WAKE_W-1:0] cnt_reg;
    logic ready_reg;
    wire last_tick = (cnt_reg == `ADCPS_WAKE_W'(1));

    // abort wins so an early chip select rise powers straight down again
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            cnt_reg <= '0;
            ready_reg <= 1'b1;
        end else if (abort_in) begin
            cnt_reg <= '0;
            ready_reg <= 1'b0;
        end else if (start_in) begin
            cnt_reg <= load_in;
            ready_reg <= 1'b0;
        end else if (cnt_reg != '0) begin
            cnt_reg <= cnt_reg - `ADCPS_WAKE_W'(1);
            ready_reg <= last_tick;
        end
    end

    assign ready_out = ready_reg;
endmodule // adcps_wake_timer

// file: design/adcps_sequencer.sv
// serial port power mode sequencer and data output control
`timescale 1ns/1ps
`include "adcps_defs.svh"
module adcps_sequencer
    import adcps_pkg::*;
#(
    parameter int FULL_WAKE_CYCLES = `ADCPS_FULL_WAKE_CYC
) (
    input wire logic ref_clk_in,
    input wire logic rst_in,
    input wire logic cs_n_in,
    input wire logic sclk_in,
    input wire adcps_result_t conv_result_in,
    output logic data_out_a_out,
    output logic data_out_a_oe_n_out,
    output logic data_out_b_out,
    output logic data_out_b_oe_n_out,
    output logic sample_out,
    output logic hold_out,
    output adcps_mode_t mode_out,
    output logic ready_out
);
    // frame for one line: two zeros, own result, two zeros, other result
    function automatic logic [`ADCPS_FRAME_W-1:0] build_frame(
        input logic [`ADCPS_RES_W-1:0] own,
        input logic [`ADCPS_RES_W-1:0] other
    );
        build_frame = {`ADCPS_ZERO2, own, `ADCPS_ZERO2, other};
    endfunction

    // next power mode from the edge count at the chip select rise
    function automatic adcps_mode_t pick_mode(
        input adcps_mode_t cur,
        input logic [5:0] cnt
    );
        adcps_mode_t res;
        res = cur;
        if (cnt >= `ADCPS_CNT_NORMAL) begin
            res = ADCPS_NORMAL;
        end else if (cnt >= `ADCPS_CNT_GLITCH) begin
            // one step deeper per cut frame
            unique case (cur)
                ADCPS_NORMAL: res = ADCPS_PARTIAL;
                ADCPS_PARTIAL: res = ADCPS_FULL;
                ADCPS_FULL: res = ADCPS_FULL;
            endcase
        end
        pick_mode = res;
    endfunction

    adcps_pins_t pins_raw;
    adcps_pins_t pins_sync;
    adcps_pins_t pins_prev_reg;
    logic [5:0] cnt_reg;
    logic [5:0] cnt_next;
    logic [`ADCPS_FRAME_W-1:0] shift_a_reg;
    logic [`ADCPS_FRAME_W-1:0] shift_b_reg;
    adcps_result_t last_res_reg;
    logic oe_n_reg;
    logic sample_reg;
    logic hold_reg;
    logic waking_reg;
    adcps_mode_t mode_reg;
    adcps_mode_t mode_next;
    logic wake_ready;

    assign pins_raw = '{cs_n: cs_n_in, sclk: sclk_in};

    adcps_pin_sync u_sync (
        .ref_clk_in(ref_clk_in),
        .rst_in(rst_in),
        .pins_in(pins_raw),
        .pins_out(pins_sync)
    );

    // edge detection on the synchronised pins
    wire cs_fall = pins_prev_reg.cs_n & ~pins_sync.cs_n;
    wire cs_rise = ~pins_prev_reg.cs_n & pins_sync.cs_n;
    wire cs_low = ~pins_sync.cs_n;
    // serial edges in the fall cycle are dropped so the first bit cannot shift early
    wire sclk_fall = pins_prev_reg.sclk & ~pins_sync.sclk & cs_low & ~cs_fall;
    wire sclk_rise = ~pins_prev_reg.sclk & pins_sync.sclk & cs_low & ~cs_fall;
    wire sat = (cnt_reg == `ADCPS_CNT_DUAL);
    assign cnt_next = sat ? cnt_reg : cnt_reg + 6'h01;
    assign mode_next = pick_mode(mode_reg, cnt_reg);
    wire wake_abort = cs_rise & (mode_next != ADCPS_NORMAL);
    wire wake_start = cs_fall & (mode_reg != ADCPS_NORMAL);
    wire [`ADCPS_WAKE_W-1:0] wake_load = (mode_reg == ADCPS_FULL) ?
        `ADCPS_WAKE_W'(FULL_WAKE_CYCLES) : `ADCPS_WAKE_W'(`ADCPS_PARTIAL_WAKE_CYC);

    adcps_wake_timer u_wake (
        .ref_clk_in(ref_clk_in),
        .rst_in(rst_in),
        .start_in(wake_start),
        .abort_in(wake_abort),
        .load_in(wake_load),
        .ready_out(wake_ready)
    );

    // pin history for edge detection
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            pins_prev_reg <= `ADCPS_PINS_IDLE;
        end else begin
            pins_prev_reg <= pins_sync;
        end
    end

    // edge counter restarts at each chip select fall
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            cnt_reg <= '0;
        end else if (cs_fall) begin
            cnt_reg <= '0;
        end else if (sclk_fall) begin
            cnt_reg <= cnt_next;
        end
    end

    // sample at the fall; the previous result goes out this frame
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            last_res_reg <= '0;
            sample_reg <= 1'b0;
        end else begin
            sample_reg <= cs_fall;
            if (cs_fall) begin
                last_res_reg <= conv_result_in;
            end
        end
    end

    // trailing zeros and other result follow from the frame layout
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            shift_a_reg <= '0;
            shift_b_reg <= '0;
        end else if (cs_fall) begin
            shift_a_reg <= build_frame(last_res_reg.res_a, last_res_reg.res_b);
            shift_b_reg <= build_frame(last_res_reg.res_b, last_res_reg.res_a);
        end else if (sclk_fall) begin
            shift_a_reg <= {shift_a_reg[`ADCPS_FRAME_W-2:0], 1'b0};
            shift_b_reg <= {shift_b_reg[`ADCPS_FRAME_W-2:0], 1'b0};
        end
    end

    // float on rise or 32nd falling edge
    // aborts float on the rise too
    // full result stays driven until the rise
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            oe_n_reg <= 1'b1;
        end else if (cs_rise) begin
            oe_n_reg <= 1'b1;
        end else if (cs_fall) begin
            oe_n_reg <= 1'b0;
        end else if (sclk_fall && cnt_next == `ADCPS_CNT_DUAL) begin
            oe_n_reg <= 1'b1;
        end
    end

    // mode changes on the rise itself, no further clocks needed
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            mode_reg <= ADCPS_NORMAL;
        end else if (cs_rise) begin
            mode_reg <= mode_next;
        end
    end

    // hold at the fall, track after 16 edges or first edge of a partial wake
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            hold_reg <= 1'b0;
            waking_reg <= 1'b0;
        end else if (cs_fall) begin
            hold_reg <= 1'b1;
            waking_reg <= (mode_reg == ADCPS_PARTIAL);
        end else if (cs_rise) begin
            hold_reg <= 1'b0;
            waking_reg <= 1'b0;
        end else if (waking_reg && (sclk_fall || sclk_rise)) begin
            hold_reg <= 1'b0;
            waking_reg <= 1'b0;
        end else if (sclk_rise && cnt_reg >= `ADCPS_CNT_RESULT) begin
            hold_reg <= 1'b0;
        end
    end

    assign data_out_a_out = shift_a_reg[`ADCPS_FRAME_W-1];
    assign data_out_b_out = shift_b_reg[`ADCPS_FRAME_W-1];
    assign data_out_a_oe_n_out = oe_n_reg;
    assign data_out_b_oe_n_out = oe_n_reg;
    assign sample_out = sample_reg;
    assign hold_out = hold_reg;
    assign mode_out = mode_reg;
    assign ready_out = wake_ready;

    // checks on the sequencer
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (rst_in);

    // a wake starts at a fall seen while in partial power-down
    sequence partial_wake_s;
        cs_fall && mode_reg == ADCPS_PARTIAL;
    endsequence
    sequence held_low_s;
        (cs_low && !cs_rise)[*8];
    endsequence

    fall_drives_zero_a: assert property (
        cs_fall |=> !data_out_a_oe_n_out && !data_out_a_out && sample_out)
        else $error("chip select fall did not drive a leading zero");
    rise_floats_a: assert property (
        cs_rise |=> data_out_a_oe_n_out && data_out_b_oe_n_out)
        else $error("outputs not floated after chip select rise");
    result_stays_driven_a: assert property (
        sclk_fall && cnt_reg == 6'h0F && !cs_rise |=> !data_out_a_oe_n_out)
        else $error("outputs floated after sixteen edges");
    trailing_zeros_a: assert property (
        !oe_n_reg && (cnt_reg == `ADCPS_CNT_RESULT || cnt_reg == `ADCPS_CNT_TRAIL)
        |-> !data_out_a_out && !data_out_b_out)
        else $error("trailing bits not zero");
    dual_frame_a: assert property (
        cs_fall ##1 (cs_low && !sclk_fall)[*1]
        |-> shift_b_reg[13:0] == $past(last_res_reg.res_a))
        else $error("other result not queued on line b");
    float_at_32_a: assert property (
        sclk_fall && cnt_reg == 6'h1F |=> data_out_a_oe_n_out && data_out_b_oe_n_out)
        else $error("line still driven after 32nd edge");
    enter_partial_a: assert property (
        cs_rise && mode_reg == ADCPS_NORMAL && cnt_reg >= 6'h02 && cnt_reg < 6'h0A
        |=> mode_reg == ADCPS_PARTIAL)
        else $error("partial power-down not entered");
    glitch_keeps_mode_a: assert property (
        cs_rise && cnt_reg < 6'h02 |=> $stable(mode_reg))
        else $error("mode changed on a short chip select pulse");
    // eight clock timer, two spare cycles for the register on ready
    partial_ready_a: assert property (
        partial_wake_s ##1 held_low_s |-> ##[0:2] ready_out)
        else $error("partial wake not ready in time");
    early_rise_down_a: assert property (
        cs_rise && mode_reg != ADCPS_NORMAL && cnt_reg < 6'h0A |=> !ready_out)
        else $error("device stayed ready after early rise");
    enter_full_a: assert property (
        cs_rise && mode_reg == ADCPS_PARTIAL && cnt_reg >= 6'h02 && cnt_reg < 6'h0A
        |=> mode_reg == ADCPS_FULL)
        else $error("full power-down not entered");
    // the host leaves four clocks between the fall and its first serial edge
    wake_track_a: assert property (
        partial_wake_s ##1 (!sclk_fall && !sclk_rise && !cs_rise)[*3] ##1
        (sclk_fall || sclk_rise) |=> !hold_out)
        else $error("hold not released on first edge of a wake");
    // a long frame must never move the power mode away from normal
    stay_powered_a: assert property (
        cs_rise && cnt_reg >= `ADCPS_CNT_NORMAL |=> mode_reg == ADCPS_NORMAL)
        else $error("long frame left normal mode");
    partial_glitch_a: assert property (
        cs_rise && mode_reg == ADCPS_PARTIAL && cnt_reg < `ADCPS_CNT_GLITCH
        |=> mode_reg == ADCPS_PARTIAL)
        else $error("short pulse moved partial power-down");
    sample_pulse_a: assert property (
        sample_out |=> !sample_out)
        else $error("sample pulse longer than one cycle");
    hold_at_fall_a: assert property (
        cs_fall |=> hold_out)
        else $error("track and hold not in hold after the fall");
    // mode moves only on a detected rise, so power-down needs no further clocks
    mode_on_rise_a: assert property (
        !cs_rise |=> $stable(mode_reg))
        else $error("mode changed without a chip select rise");
    track_after_16_a: assert property (
        sclk_rise && cnt_reg >= `ADCPS_CNT_RESULT |=> !hold_out)
        else $error("hold not released after sixteen edges");
endmodule // adcps_sequencer

// file: dv/adcps_host_model.sv
// host serial port model: chip select and serial clock frames, line capture
`timescale 1ns/1ps
module adcps_host_model
    import adcps_pkg::*;
(
    input wire logic data_a_in,
    input wire logic oe_a_n_in,
    input wire logic data_b_in,
    input wire logic oe_b_n_in,
    output logic cs_n_out,
    output logic sclk_out
);
    logic held_a = 1'b0;
    logic held_b = 1'b0;
    logic line_a;
    logic line_b;
    logic [31:0] cap_a;
    logic [31:0] cap_b;
    logic [1:0] last_oe_n;

    // a released line shows the inverse of its last driven level, never a stale copy
    always @(data_a_in, oe_a_n_in, data_b_in, oe_b_n_in) begin
        if (!oe_a_n_in) held_a = data_a_in;
        if (!oe_b_n_in) held_b = data_b_in;
    end
    assign line_a = oe_a_n_in ? ~held_a : data_a_in;
    assign line_b = oe_b_n_in ? ~held_b : data_b_in;

    // serial clock stands low outside frames
    initial begin
        cs_n_out = 1'b1;
        sclk_out = 1'b0;
    end

    // frame of n falls, then quiet time
    task automatic frame(input int n);
        cap_a = '0;
        cap_b = '0;
        cs_n_out = 1'b0;
        #100;
        for (int k = 0; k < n; k++) begin
            sclk_out = 1'b1;
            #100;
            cap_a = {cap_a[30:0], line_a};
            cap_b = {cap_b[30:0], line_b};
            sclk_out = 1'b0;
            #100;
        end
        #50;
        last_oe_n = {oe_a_n_in, oe_b_n_in};
        #50;
        cs_n_out = 1'b1;
        #400;
    endtask
endmodule // adcps_host_model

// file: dv/test_adc_cs_power_mode_sequencer.sv
// self-checking bench for the chip select power mode sequencer
`timescale 1ns/1ps
module test_adc_cs_power_mode_sequencer
    import adcps_pkg::*;
;
    typedef struct {
        int n;
        adcps_mode_t mode;
        logic rdy;
        logic chk;
    } adcps_row_t;

    logic ref_clk_in = 1'b0;
    logic rst_in = 1'b1;
    adcps_result_t conv = '0;
    adcps_result_t cur = '0;
    adcps_result_t prev;
    logic cs_n;
    logic sclk;
    logic da;
    logic da_oe_n;
    logic db;
    logic db_oe_n;
    logic sample;
    logic hold;
    adcps_mode_t mode;
    logic ready;
    int failures = 0;
    int cmp_count = 0;
    int cycles = 0;
    int pulses = 0;
    logic hold_at_rise;
    logic hold_exp;
    logic [31:0] exp_a;
    logic [31:0] exp_b;
    adcps_mode_t mode_before = ADCPS_NORMAL;

    // mode walk: falls per frame, then expected mode and ready
    adcps_row_t rows [14] = '{
        '{1, ADCPS_NORMAL, 1'b1, 1'b0}, '{16, ADCPS_NORMAL, 1'b1, 1'b1},
        '{5, ADCPS_PARTIAL, 1'b0, 1'b0}, '{1, ADCPS_PARTIAL, 1'b0, 1'b0},
        '{5, ADCPS_FULL, 1'b0, 1'b0}, '{9, ADCPS_FULL, 1'b0, 1'b0},
        '{12, ADCPS_NORMAL, 1'b1, 1'b0}, '{3, ADCPS_PARTIAL, 1'b0, 1'b1},
        '{12, ADCPS_NORMAL, 1'b1, 1'b0}, '{32, ADCPS_NORMAL, 1'b1, 1'b1},
        '{2, ADCPS_PARTIAL, 1'b0, 1'b0}, '{10, ADCPS_NORMAL, 1'b1, 1'b0},
        '{10, ADCPS_NORMAL, 1'b1, 1'b1}, '{18, ADCPS_NORMAL, 1'b1, 1'b1}};

    always #12.5 ref_clk_in = ~ref_clk_in;

    // short full wake keeps the run brief
    adcps_sequencer #(.FULL_WAKE_CYCLES(50)) dut_u (
        .ref_clk_in(ref_clk_in), .rst_in(rst_in), .cs_n_in(cs_n), .sclk_in(sclk),
        .conv_result_in(conv), .data_out_a_out(da), .data_out_a_oe_n_out(da_oe_n),
        .data_out_b_out(db), .data_out_b_oe_n_out(db_oe_n), .sample_out(sample),
        .hold_out(hold), .mode_out(mode), .ready_out(ready));

    adcps_host_model host_u (
        .data_a_in(da), .oe_a_n_in(da_oe_n), .data_b_in(db), .oe_b_n_in(db_oe_n),
        .cs_n_out(cs_n), .sclk_out(sclk));

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // whole 32-bit line frame, bit k at position 31-k
    function automatic logic [31:0] fr(input logic [13:0] a, input logic [13:0] b);
        return {2'h0, a, 2'h0, b};
    endfunction

    task automatic idle_checks(input string name);
        check(name, {26'h0, da_oe_n, db_oe_n, 1'b0, mode}, {26'h0, 2'h3, 4'h1});
        check("ready", {31'h0, ready}, 32'h1);
    endtask

    task automatic end_sim();
        $display("comparisons %0d failures %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    // hold level as the host raises chip select, before the sequencer sees the rise
    always @(posedge cs_n) hold_at_rise = hold;

    // sample pulses counted mid-cycle, where the registered pulse has settled
    always @(negedge ref_clk_in) begin
        if (sample) pulses++;
    end

    // hang guard, far above the roughly 1750 cycles the run needs
    always @(posedge ref_clk_in) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            end_sim();
        end
    end

    initial begin
        repeat (3) @(posedge ref_clk_in);
        #2;
        idle_checks("reset_idle");
        rst_in = 1'b0;
        repeat (4) @(posedge ref_clk_in);
        for (int i = 0; i < 14; i++) begin
            prev = cur;
            cur = {14'h2A51 + 14'(i * 37), 14'h1C3E ^ 14'(i * 91)};
            @(posedge ref_clk_in);
            #2;
            conv = cur;
            host_u.frame(rows[i].n);
            repeat (12) @(posedge ref_clk_in);
            #2;
            check("mode", 32'(mode), 32'(rows[i].mode));
            check("ready", {31'h0, ready}, {31'h0, rows[i].rdy});
            check("oe_low", {30'h0, host_u.last_oe_n}, (rows[i].n >= 32) ? 32'h3 : 32'h0);
            check("oe_off", {30'h0, da_oe_n, db_oe_n}, 32'h3);
            // a partial wake releases hold on its first edge, else only after sixteen falls
            hold_exp = (mode_before != ADCPS_PARTIAL) && (rows[i].n <= 16);
            check("hold", {31'h0, hold_at_rise}, {31'h0, hold_exp});
            mode_before = rows[i].mode;
            exp_a = fr(prev.res_a, prev.res_b) >> (32 - rows[i].n);
            exp_b = fr(prev.res_b, prev.res_a) >> (32 - rows[i].n);
            if (rows[i].chk) begin
                check("line_a", host_u.cap_a, exp_a);
                check("line_b", host_u.cap_b, exp_b);
            end
        end
        // second reset in power-down: sequencer must restart in normal mode
        host_u.frame(4);
        @(posedge ref_clk_in);
        #2;
        check("mode", 32'(mode), 32'(ADCPS_PARTIAL));
        rst_in = 1'b1;
        repeat (3) @(posedge ref_clk_in);
        #2;
        idle_checks("mid_reset");
        rst_in = 1'b0;
        repeat (4) @(posedge ref_clk_in);
        #2;
        // counter and mode logic must work again after the mid-run reset
        host_u.frame(5);
        repeat (12) @(posedge ref_clk_in);
        #2;
        check("mode", 32'(mode), 32'(ADCPS_PARTIAL));
        check("ready", {31'h0, ready}, 32'h0);
        check("sample", pulses, 32'h10);
        end_sim();
    end
endmodule // test_adc_cs_power_mode_sequencer
